/* File: core/mcmr_regs.svh */
// Register map, field positions, reset values and timing counts
`ifndef MCMR_REGS_SVH
`define MCMR_REGS_SVH

// ************************************************************
// Command byte layout
// ************************************************************
`define MCMR_CMD_WRITE_BIT      7
`define MCMR_CMD_ADDR_MSB       5
`define MCMR_ADDR_W             6

// ************************************************************
// Operating configuration register
// ************************************************************
`define MCMR_OPCFG_ADDR         6'h09
`define MCMR_OPCFG_BYTES        2'h2
`define MCMR_OTHER_BYTES        2'h1
`define MCMR_OPCFG_RESET        16'h000C
`define MCMR_BIT_HPF_BYP        0
`define MCMR_BIT_LPF_BYP        1
`define MCMR_BIT_PULSE_OFF      2
`define MCMR_BIT_SAG_OFF        3
`define MCMR_BIT_ADC_PD         4
`define MCMR_BIT_TEMP_GO        5
`define MCMR_BIT_SOFTWARE_CHIP_RESET          6
`define MCMR_BIT_CYCLE          7
`define MCMR_BIT_CUR_SHORT      8
`define MCMR_BIT_VOLT_SHORT     9
`define MCMR_BIT_SWAP           10
`define MCMR_RATE_LSB           11
`define MCMR_RATE_MSB           12
`define MCMR_SRC_LSB            13
`define MCMR_SRC_MSB            14
`define MCMR_BIT_POS_ONLY       15

// ************************************************************
// Timing
// ************************************************************
`define MCMR_CLK_PERIOD_NS      10
`define MCMR_SOFTWARE_CHIP_RESET_HOLD_NS      18000
`define MCMR_SOFTWARE_CHIP_RESET_HOLD_CYC     \
  ((`MCMR_SOFTWARE_CHIP_RESET_HOLD_NS + `MCMR_CLK_PERIOD_NS - 1) / `MCMR_CLK_PERIOD_NS)
`define MCMR_RATE_BASE_DIV      11'h080

`endif

/* File: core/mcmr_pkg.sv */
// Types shared by the command and configuration block
package mcmr_pkg;
  typedef enum logic {MCMR_ST_CMD, MCMR_ST_DATA} mcmr_state_e;
  typedef logic [1:0]  mcmr_sel_t;
  typedef logic [7:0]  mcmr_byte_t;
  typedef logic [15:0] mcmr_word_t;
endpackage

/* File: core/mcmr_serial.sv */
// Serial byte engine: pin synchronisers, edge finding, byte shifter
module mcmr_serial (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              cs_n_pin,
  input  wire logic              sclk_pin,
  input  wire logic              din_pin,
  input  wire mcmr_pkg::mcmr_byte_t tx_byte,
  input  wire logic              drive_en,
  output logic                   frame_active,
  output logic                   byte_done,
  output mcmr_pkg::mcmr_byte_t   rx_byte,
  output logic                   dout,
  output logic                   dout_oe
);
  import mcmr_pkg::*;

  // ************************************************************
  // Two-stage synchronisers
  // ************************************************************
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic       sclk_prev_r;
  logic [2:0] cnt_r;
  mcmr_byte_t rx_sh_r;
  mcmr_byte_t tx_sh_r;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r      <= 3'h1;
      sync_r      <= 3'h1;
      sclk_prev_r <= 1'b0;
    end else if (ce) begin
      meta_r      <= {din_pin, sclk_pin, cs_n_pin};
      sync_r      <= meta_r;
      sclk_prev_r <= sync_r[1];
    end
  end

  assign frame_active = ~sync_r[0];
  assign rise = frame_active & sync_r[1] & ~sclk_prev_r;
  assign fall = frame_active & ~sync_r[1] & sclk_prev_r;

  // ************************************************************
  // Byte shifter, MSB first; input taken on the falling edge
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= 3'h0;
      rx_sh_r   <= 8'h00;
      tx_sh_r   <= 8'h00;
      rx_byte   <= 8'h00;
      byte_done <= 1'b0;
    end else if (ce) begin
      byte_done <= 1'b0;
      if (!frame_active) begin
        cnt_r <= 3'h0;
      end else if (fall) begin
        rx_sh_r <= {rx_sh_r[6:0], sync_r[2]};
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        cnt_r   <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          rx_byte   <= {rx_sh_r[6:0], sync_r[2]};
          byte_done <= 1'b1;
        end
      end else if (rise && cnt_r == 3'h0) begin
        tx_sh_r <= tx_byte;
      end
    end
  end

  // Output bit changes on the rising edge, ahead of the host's sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (ce) begin
      dout_oe <= frame_active & drive_en;
      if (rise) begin
        dout <= (cnt_r == 3'h0) ? tx_byte[7] : tx_sh_r[7];
      end
    end
  end
endmodule

/* File: core/mcmr_top.sv */
// Command byte front end and operating configuration register
`include "mcmr_regs.svh"

// Overview of operation
// R1: Command byte is eight bits, write only, and sets up the next transfer.
// R2: Host opens every transfer with a command byte.
// R3: Low six command bits give the target register index.
// R4: Host keeps command bit six at zero.
// R5: Command bit seven one means write, zero means read.
// R6: Configuration register sits at index nine and holds operating options.
// R7: Bit zero bypasses current-channel high-pass filter; resets to zero.
// R8: Bit one bypasses the power low-pass filter; resets to zero.
// R9: Bits two and three disable pulse output and sag detect; reset one.
// R10: Bit four powers down both converters; resets to zero.
// R11: Bit five starts a temperature conversion and self-clears when done.
// R12: Bit six resets the chip; no access for 18 us afterwards.
// R13: Bit seven selects line-cycle accumulation; zero is normal.
// R14: Bit eight shorts the current converter inputs.
// R15: Bit nine shorts the voltage converter inputs.
// R16: Bit ten swaps the two channel inputs between converters.
// R17: Bits twelve and eleven pick waveform rate clock/128 to /1024.
// R18: Bits fourteen and thirteen pick the waveform source; 01 reserved.
// R19: Bit fifteen accumulates only positive power.
// R20: Register byte count follows the command, MSB first, then new command.
module mcmr_top (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            ce,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_sclk,
  input  wire logic            spi_din,
  output logic                 spi_dout,
  output logic                 spi_dout_oe,
  input  wire logic            temp_done,
  output logic                 current_highpass_bypass,
  output logic                 power_lowpass_bypass,
  output logic                 pulse_output_off,
  output logic                 sag_detect_off,
  output logic                 converter_powerdown,
  output logic                 temperature_convert_start,
  output logic                 software_chip_reset,
  output logic                 line_cycle_accumulate,
  output logic                 current_input_short,
  output logic                 voltage_input_short,
  output logic                 channel_swap,
  output mcmr_pkg::mcmr_sel_t  waveform_rate_select,
  output mcmr_pkg::mcmr_sel_t  waveform_source_select,
  output logic                 positive_only_accumulate,
  output logic                 waveform_sample_strobe,
  output logic                 access_holdoff
);
  import mcmr_pkg::*;

  localparam logic [10:0] HOLD_CYC = 11'(`MCMR_SOFTWARE_CHIP_RESET_HOLD_CYC);
  localparam int          HOLD_I   = `MCMR_SOFTWARE_CHIP_RESET_HOLD_CYC;

  // Byte count of the addressed register; unmapped indexes move one byte
  function automatic logic [1:0] byte_count(input logic [5:0] idx);
    byte_count = (idx == `MCMR_OPCFG_ADDR) ? `MCMR_OPCFG_BYTES
                                           : `MCMR_OTHER_BYTES;
  endfunction

  function automatic logic [10:0] rate_div(input mcmr_sel_t sel);
    rate_div = `MCMR_RATE_BASE_DIV << sel;
  endfunction

  // ************************************************************
  // Serial engine
  // ************************************************************
  logic        frame_active;
  logic        byte_done;
  mcmr_byte_t  rx_byte;
  mcmr_byte_t  tx_byte;
  logic        drive_en;

  mcmr_serial u_serial (
    .clk          (clk),
    .arst_n       (arst_n),
    .ce           (ce),
    .cs_n_pin     (spi_cs_n),
    .sclk_pin     (spi_sclk),
    .din_pin      (spi_din),
    .tx_byte      (tx_byte),
    .drive_en     (drive_en),
    .frame_active (frame_active),
    .byte_done    (byte_done),
    .rx_byte      (rx_byte),
    .dout         (spi_dout),
    .dout_oe      (spi_dout_oe)
  );

  // ************************************************************
  // Command and data sequencing
  // ************************************************************
  mcmr_state_e state_r;
  mcmr_byte_t  cmd_r;
  mcmr_byte_t  wbuf_r;
  logic [1:0]  left_r;
  mcmr_word_t  opcfg_r;
  mcmr_word_t  opcfg_nxt;
  mcmr_word_t  rd_word;
  mcmr_word_t  wr_word;
  logic [10:0] hold_r;
  logic        take;
  logic        wr_go;
  logic        is_write;
  logic [5:0]  target_register_index;

  assign take = byte_done & frame_active & (hold_r == 11'h000);
  assign target_register_index = cmd_r[`MCMR_CMD_ADDR_MSB:0];       // [R3]
  assign is_write = cmd_r[`MCMR_CMD_WRITE_BIT];                     // [R5]
  assign wr_word  = {wbuf_r, rx_byte};
  // Command register has no read path; only index nine reads back
  assign rd_word  = (target_register_index == `MCMR_OPCFG_ADDR)
                    ? opcfg_r : 16'h0000;                           // [R1]
  assign wr_go = take && state_r == MCMR_ST_DATA && left_r == 2'h1 &&
                 is_write && target_register_index == `MCMR_OPCFG_ADDR;
  assign drive_en = (state_r == MCMR_ST_DATA) & ~is_write;          // [R5]
  assign tx_byte  = (left_r == 2'h2) ? rd_word[15:8] : rd_word[7:0]; // [R20]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= MCMR_ST_CMD;
      cmd_r   <= 8'h00;
      wbuf_r  <= 8'h00;
      left_r  <= 2'h0;
    end else if (ce) begin
      if (!frame_active) begin
        state_r <= MCMR_ST_CMD;
      end else if (take) begin
        case (state_r)
          MCMR_ST_CMD: begin
            cmd_r   <= rx_byte;                                     // [R1]
            left_r  <= byte_count(rx_byte[`MCMR_CMD_ADDR_MSB:0]);   // [R20]
            state_r <= MCMR_ST_DATA;
          end
          MCMR_ST_DATA: begin
            wbuf_r <= rx_byte;
            left_r <= left_r - 2'h1;
            if (left_r == 2'h1) begin
              state_r <= MCMR_ST_CMD;                               // [R20]
            end
          end
          default: state_r <= MCMR_ST_CMD;
        endcase
      end
    end
  end

  // ************************************************************
  // Operating configuration register
  // ************************************************************
  always_comb begin
    opcfg_nxt = wr_go ? wr_word : opcfg_r;                          // [R6]
    opcfg_nxt[`MCMR_BIT_SOFTWARE_CHIP_RESET] = 1'b0;
    // A fresh start in the same cycle wins over the completion clear
    if (temp_done && !(wr_go && wr_word[`MCMR_BIT_TEMP_GO])) begin
      opcfg_nxt[`MCMR_BIT_TEMP_GO] = 1'b0;                          // [R11]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opcfg_r             <= `MCMR_OPCFG_RESET;                     // [R9]
      software_chip_reset <= 1'b0;
      hold_r              <= 11'h000;
    end else if (ce) begin
      software_chip_reset <= wr_go & wr_word[`MCMR_BIT_SOFTWARE_CHIP_RESET];
      if (wr_go && wr_word[`MCMR_BIT_SOFTWARE_CHIP_RESET]) begin
        opcfg_r <= `MCMR_OPCFG_RESET;                               // [R12]
        hold_r  <= HOLD_CYC;
      end else begin
        opcfg_r <= opcfg_nxt;
        if (hold_r != 11'h000) begin
          hold_r <= hold_r - 11'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      access_holdoff <= 1'b0;
    end else if (ce) begin
      access_holdoff <= (wr_go && wr_word[`MCMR_BIT_SOFTWARE_CHIP_RESET]) ||
                        hold_r > 11'h001;                           // [R12]
    end
  end

  assign current_highpass_bypass   = opcfg_r[`MCMR_BIT_HPF_BYP];    // [R7]
  assign power_lowpass_bypass      = opcfg_r[`MCMR_BIT_LPF_BYP];    // [R8]
  assign pulse_output_off          = opcfg_r[`MCMR_BIT_PULSE_OFF];  // [R9]
  assign sag_detect_off            = opcfg_r[`MCMR_BIT_SAG_OFF];    // [R9]
  assign converter_powerdown       = opcfg_r[`MCMR_BIT_ADC_PD];     // [R10]
  assign temperature_convert_start = opcfg_r[`MCMR_BIT_TEMP_GO];    // [R11]
  assign line_cycle_accumulate     = opcfg_r[`MCMR_BIT_CYCLE];      // [R13]
  assign current_input_short       = opcfg_r[`MCMR_BIT_CUR_SHORT];  // [R14]
  assign voltage_input_short       = opcfg_r[`MCMR_BIT_VOLT_SHORT]; // [R15]
  assign channel_swap              = opcfg_r[`MCMR_BIT_SWAP];       // [R16]
  assign waveform_rate_select      =
    opcfg_r[`MCMR_RATE_MSB:`MCMR_RATE_LSB];                         // [R17]
  assign waveform_source_select    =
    opcfg_r[`MCMR_SRC_MSB:`MCMR_SRC_LSB];                           // [R18]
  assign positive_only_accumulate  = opcfg_r[`MCMR_BIT_POS_ONLY];   // [R19]

  // ************************************************************
  // Waveform sample pacing
  // ************************************************************
  logic [10:0] wav_cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wav_cnt_r              <= 11'h000;
      waveform_sample_strobe <= 1'b0;
    end else if (ce) begin
      // Rate change takes effect at once; a shorter period may wrap early
      if (wav_cnt_r >= rate_div(waveform_rate_select) - 11'h001) begin
        wav_cnt_r              <= 11'h000;
        waveform_sample_strobe <= 1'b1;                             // [R17]
      end else begin
        wav_cnt_r              <= wav_cnt_r + 11'h001;
        waveform_sample_strobe <= 1'b0;
      end
    end
  end

  // Gap since the last strobe; only trusted while the rate stood still
  logic [10:0] gap_r;
  logic        rate_kept_r;
  mcmr_sel_t   rate_seen_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r       <= 11'h000;
      rate_kept_r <= 1'b0;
      rate_seen_r <= 2'h0;
    end else if (ce) begin
      if (waveform_sample_strobe) begin
        gap_r       <= 11'h001;
        rate_kept_r <= 1'b1;
        rate_seen_r <= waveform_rate_select;
      end else begin
        gap_r <= gap_r + 11'h001;
        if (waveform_rate_select != rate_seen_r) begin
          rate_kept_r <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  AST_CMD_OPENS_DATA: assert property ( // [R1]
    @(posedge clk) disable iff (!arst_n)
    ce && take && state_r == MCMR_ST_CMD |=> state_r == MCMR_ST_DATA &&
      cmd_r == $past(rx_byte))
    else $error("command byte not captured");
  AST_INDEX_LOW_SIX: assert property ( // [R3]
    @(posedge clk) disable iff (!arst_n)
    ce && take && state_r == MCMR_ST_CMD |=>
      target_register_index == $past(rx_byte[5:0]))
    else $error("target index wrong");
  AST_READ_DRIVES: assert property ( // [R5]
    @(posedge clk) disable iff (!arst_n)
    ce && state_r == MCMR_ST_DATA && frame_active |=>
      spi_dout_oe == !$past(cmd_r[7]))
    else $error("direction wrong");
  AST_WRITE_LANDS: assert property ( // [R6]
    @(posedge clk) disable iff (!arst_n)
    ce && wr_go && !wr_word[6] |=> opcfg_r[15:6] == $past(wr_word[15:6]))
    else $error("configuration write lost");
  AST_TEMP_CLEARS: assert property ( // [R11]
    @(posedge clk) disable iff (!arst_n)
    ce && temp_done && !wr_go |=> !temperature_convert_start)
    else $error("temperature start not cleared");
  AST_SOFTWARE_CHIP_RESET_DEFAULTS: assert property ( // [R12]
    @(posedge clk) disable iff (!arst_n)
    ce && wr_go && wr_word[6] |=> opcfg_r == 16'h000C &&
      software_chip_reset ##1 access_holdoff[*8])
    else $error("software reset incomplete");
  AST_HOLDOFF_BLOCKS: assert property ( // [R12]
    @(posedge clk) disable iff (!arst_n)
    ce && hold_r != 11'h000 |=> state_r == MCMR_ST_CMD && $stable(cmd_r))
    else $error("access taken during hold-off");
  AST_HOLD_LENGTH: assert property ( // [R12]
    @(posedge clk) disable iff (!arst_n)
    ce && wr_go && wr_word[6] |=> hold_r == 11'(HOLD_I))
    else $error("hold-off length wrong");
  AST_COUNT_ENDS: assert property ( // [R20]
    @(posedge clk) disable iff (!arst_n)
    ce && take && state_r == MCMR_ST_DATA && left_r == 2'h1 |=>
      state_r == MCMR_ST_CMD)
    else $error("transfer did not end");
  AST_RATE_PERIOD: assert property ( // [R17]
    @(posedge clk) disable iff (!arst_n)
    ce && waveform_sample_strobe && rate_kept_r |->
      gap_r == (`MCMR_RATE_BASE_DIV << rate_seen_r))
    else $error("waveform rate wrong");

  COV_WRITE_CFG: cover property (@(posedge clk) disable iff (!arst_n)
    wr_go && !wr_word[6]);
  COV_READ_CFG: cover property (@(posedge clk) disable iff (!arst_n)
    state_r == MCMR_ST_DATA && !is_write && left_r == 2'h2);
  COV_SOFTWARE_CHIP_RESET: cover property (@(posedge clk) disable iff (!arst_n)
    wr_go && wr_word[6]);
  COV_TEMP: cover property (@(posedge clk) disable iff (!arst_n)
    temperature_convert_start ##1 !temperature_convert_start);
endmodule

/* File: bench/mcmr_host_model.sv */
// Host model: drives the serial link as the metering controller would
module mcmr_host_model (
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Idle link
  // ****************************************
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // ****************************************
  // Byte and frame transfer
  // ****************************************
  // New bit after rise, held past the fall where the device takes it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      #62.5;
      sclk  = 1'b0;
      // Undriven line reads as the inverse of its last bit
      rx[i] = dout_oe ? dout : ~dout;
      #62.5;
    end
  endtask

  task automatic access(input logic wr, input logic [5:0] idx,
                        input logic [15:0] wd, input int nb,
                        output logic [15:0] rd);
    logic [7:0] b;
    rd   = 16'h0000;
    cs_n = 1'b0;
    #100;
    xfer({wr, 1'b0, idx}, b);
    for (int k = nb - 1; k >= 0; k--) begin
      xfer(wd[8*k +: 8], b);
      rd[8*k +: 8] = b;
    end
    #100;
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    din = ~din;
    // Deselect long enough for the device to see the frame end
    #100;
  endtask
endmodule

/* File: bench/meter_command_and_mode_regs_tb_top.sv */
// Testbench for the command front end and configuration register
module meter_command_and_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        arst_n;
  logic        ce;
  logic        temp_done;
  logic        spi_cs_n;
  logic        spi_sclk;
  logic        spi_din;
  logic        spi_dout;
  logic        spi_dout_oe;
  logic        sw_rst;
  logic        strobe;
  logic        holdoff;
  wire  [15:0] obs;
  logic [15:0] cfg_m;
  logic [15:0] rd;
  logic [31:0] seed;
  int          n_mismatch;
  int          checks_done;
  int          n_software_chip_reset;
  int          n_hold;
  int          n;

  always #5 clk = ~clk;

  mcmr_host_model host (
    .dout    (spi_dout),
    .dout_oe (spi_dout_oe),
    .cs_n (spi_cs_n),
    .sclk (spi_sclk),
    .din  (spi_din)
  );

  mcmr_top dut (
    .clk                       (clk),
    .arst_n                    (arst_n),
    .ce                        (ce),
    .spi_cs_n                  (spi_cs_n),
    .spi_sclk                  (spi_sclk),
    .spi_din                   (spi_din),
    .spi_dout                  (spi_dout),
    .spi_dout_oe               (spi_dout_oe),
    .temp_done                 (temp_done),
    .current_highpass_bypass   (obs[0]),
    .power_lowpass_bypass      (obs[1]),
    .pulse_output_off          (obs[2]),
    .sag_detect_off            (obs[3]),
    .converter_powerdown       (obs[4]),
    .temperature_convert_start (obs[5]),
    .software_chip_reset       (sw_rst),
    .line_cycle_accumulate     (obs[7]),
    .current_input_short       (obs[8]),
    .voltage_input_short       (obs[9]),
    .channel_swap              (obs[10]),
    .waveform_rate_select      (obs[12:11]),
    .waveform_source_select    (obs[14:13]),
    .positive_only_accumulate  (obs[15]),
    .waveform_sample_strobe    (strobe),
    .access_holdoff            (holdoff)
  );
  assign obs[6] = 1'b0;

  always @(posedge clk) begin
    if (sw_rst === 1'b1)
      n_software_chip_reset <= n_software_chip_reset + 1;
    if (holdoff === 1'b1)
      n_hold <= n_hold + 1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_cfg();
    check(obs, cfg_m);
    host.access(1'b0, 6'h09, 16'h0000, 2, rd);
    check(rd, cfg_m);
  endtask

  // Chip reset bit is a pulse, never stored
  task automatic wr_cfg(input logic [15:0] v);
    host.access(1'b1, 6'h09, v, 2, rd);
    cfg_m = v & 16'hFFBF;
    @(posedge clk);
    #1;
    chk_cfg();
  endtask

  task automatic measure(output int cnt);
    cnt = 0;
    while (strobe !== 1'b1 && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (strobe !== 1'b1 && cnt < 2000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    temp_done = 1'b0;
    seed = 32'h0000_6977;
    n_mismatch = 0;
    checks_done = 0;
    n_software_chip_reset = 0;
    n_hold = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cfg_m = 16'h000C;
    check(obs, cfg_m);
    host.access(1'b0, 6'h09, 16'h0000, 2, rd);
    check(rd, 16'h000C);
    $display("test reset done");

    for (int j = 0; j < 6; j++) begin
      seed = xs(seed);
      wr_cfg(seed[15:0] & 16'hFF9F);
    end
    $display("test random config done");

    for (int r = 0; r < 4; r++) begin
      wr_cfg({1'b0, 2'(r), 2'(r), 11'h00C});
      measure(n);
      check(16'(n), 16'(128 << r));
    end
    $display("test sample rate done");

    wr_cfg(cfg_m | 16'h0020);
    check({15'h0000, obs[5]}, 16'h0001);
    @(posedge clk);
    temp_done <= 1'b1;
    @(posedge clk);
    temp_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, obs[5]}, 16'h0000);
    cfg_m &= 16'hFFDF;
    chk_cfg();
    $display("test temperature done");

    // Indexes one bit away from nine must not reach the register
    for (int i = 0; i < 4; i++) begin
      host.access(1'b1, 6'h08 ^ 6'(1 << i) ^ 6'h01, 16'h00FF, 1, rd);
      check(obs, cfg_m);
    end
    host.access(1'b0, 6'h0A, 16'h0000, 1, rd);
    check(rd, 16'h0000);
    host.access(1'b1, 6'h09, 16'h00FF, 1, rd);
    chk_cfg();
    $display("test decode and abort done");

    n = n_software_chip_reset;
    host.access(1'b1, 6'h09, 16'h0043, 2, rd);
    cfg_m = 16'h000C;
    check({15'h0000, holdoff}, 16'h0001);
    check(16'(n_software_chip_reset - n), 16'h0001);
    check(obs, cfg_m);
    host.access(1'b1, 6'h09, 16'h0003, 2, rd);
    // Write above falls inside the hold-off and is dropped; wait for the hold-off to end
    for (int k = 0; k < 3000 && holdoff !== 1'b0; k++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    check(16'(n_hold), 16'd1800);
    chk_cfg();
    $display("test software reset done");
    report_and_stop();
  end

  initial begin
    #800us;
    n_mismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
